// [verilog/io_port_pkg.sv]
package io_port_pkg;

    // APB address width; the highest register index times four needs 18 bits.
    localparam int unsigned ADDR_W = 18;

    // Register indices as printed; the byte address is four times the index.
    localparam logic [15:0] P3_FSEL_IDX = 16'hffca;
    localparam logic [15:0] P3_LAT_IDX  = 16'hffd6;
    localparam logic [15:0] P3_PU_IDX   = 16'hffe1;
    localparam logic [15:0] P3_DIR_IDX  = 16'hffe6;
    localparam logic [15:0] P1_FSEL_IDX = 16'hffc8;
    localparam logic [15:0] P1_LAT_IDX  = 16'hffd4;
    localparam logic [15:0] P1_PU_IDX   = 16'hffe0;
    localparam logic [15:0] P1_DIR_IDX  = 16'hffe4;

    localparam logic [ADDR_W-1:0] P3_FSEL_ADDR = {P3_FSEL_IDX, 2'b00};
    localparam logic [ADDR_W-1:0] P3_LAT_ADDR  = {P3_LAT_IDX, 2'b00};
    localparam logic [ADDR_W-1:0] P3_PU_ADDR   = {P3_PU_IDX, 2'b00};
    localparam logic [ADDR_W-1:0] P3_DIR_ADDR  = {P3_DIR_IDX, 2'b00};
    localparam logic [ADDR_W-1:0] P1_FSEL_ADDR = {P1_FSEL_IDX, 2'b00};
    localparam logic [ADDR_W-1:0] P1_LAT_ADDR  = {P1_LAT_IDX, 2'b00};
    localparam logic [ADDR_W-1:0] P1_PU_ADDR   = {P1_PU_IDX, 2'b00};
    localparam logic [ADDR_W-1:0] P1_DIR_ADDR  = {P1_DIR_IDX, 2'b00};

    // Reset values.
    localparam logic [7:0] P3_FSEL_RST = 8'h04;
    localparam logic [7:0] P3_LAT_RST  = 8'h00;
    localparam logic [7:0] P3_PU_RST   = 8'h00;
    localparam logic [7:0] P3_DIR_RST  = 8'h00;
    localparam logic [7:0] P1_FSEL_RST = 8'h00;
    localparam logic [7:0] P1_LAT_RST  = 8'h00;
    localparam logic [7:0] P1_PU_RST   = 8'h00;
    localparam logic [7:0] P1_DIR_RST  = 8'h00;
    // The port 3 direction register is write-only and reads as all ones.
    localparam logic [7:0] P3_DIR_READ = 8'hff;

    // Port 1 function select bit positions.
    localparam int unsigned P1_CAPTURE_BIT = 3;
    localparam int unsigned P1_TMR_HI_BIT  = 2;
    localparam int unsigned P1_TMR_LO_BIT  = 1;
    localparam int unsigned P1_WATCH_BIT   = 0;

    // Port 3 function select bits that steer a pin, and those that make it an output.
    localparam logic [7:0] P3_PIN_SEL_MASK = 8'hc7;
    localparam logic [7:0] P3_ALT_OUT_MASK = 8'h05;
    localparam int unsigned P3_RESET_STAT_BIT = 2;
    localparam int unsigned P3_PWM_BIT        = 0;

    // Reset pin drive on port 3: the reset status pin drives low while in reset.
    localparam logic [7:0] P3_OE_RST  = 8'h04;
    localparam logic [7:0] P3_OUT_RST = 8'h00;

    // Operating mode from the power controller; unused codes are treated as standby.
    typedef enum logic [2:0] {
        MODE_ACTIVE    = 3'h0,
        MODE_SUBACTIVE = 3'h1,
        MODE_SUBSLEEP  = 3'h3,
        MODE_SLEEP     = 3'h2,
        MODE_WATCH     = 3'h6,
        MODE_STANDBY   = 3'h7
    } op_mode_t;

endpackage : io_port_pkg

// [verilog/io_port_pin_control.sv]
`timescale 1ns/1ps
module io_port_pin_control (
    input  wire logic                           ref_clk,
    input  wire logic                           rst_n,
    input  wire logic                           psel,
    input  wire logic                           penable,
    input  wire logic                           pwrite,
    input  wire logic [io_port_pkg::ADDR_W-1:0] paddr,
    input  wire logic [31:0]                    pwdata,
    output logic                                pready,
    output logic      [31:0]                    prdata,
    output logic                                pslverr,
    input  wire io_port_pkg::op_mode_t          op_mode,
    input  wire logic [7:0]                     p1_pin_in,
    output logic      [7:0]                     p1_pin_out,
    output logic      [7:0]                     p1_pin_oe,
    output logic      [7:0]                     p1_pullup_on,
    input  wire logic [7:0]                     p3_pin_in,
    output logic      [7:0]                     p3_pin_out,
    output logic      [7:0]                     p3_pin_oe,
    output logic      [7:0]                     p3_pullup_on,
    input  wire logic                           timer_output_high,
    input  wire logic                           timer_output_low,
    input  wire logic                           watch_clock_output,
    input  wire logic                           pwm_output,
    input  wire logic                           reset_status_output_n,
    output logic                                timer_capture_input,
    output logic      [7:0]                     p3_alt_input,
    output logic      [7:0]                     port3_function_select
);

    typedef struct packed {
        logic [7:0]  p1_sync1;
        logic [7:0]  p1_sync2;
        logic [7:0]  p3_sync1;
        logic [7:0]  p3_sync2;
        logic [7:0]  p1_lat;
        logic [7:0]  p1_dir;
        logic [7:0]  p1_pu;
        logic [7:0]  p1_fsel;
        logic [7:0]  p3_lat;
        logic [7:0]  p3_dir;
        logic [7:0]  p3_pu;
        logic [7:0]  p3_fsel;
        logic [7:0]  p1_out;
        logic [7:0]  p1_oe;
        logic [7:0]  p1_pull;
        logic [7:0]  p3_out;
        logic [7:0]  p3_oe;
        logic [7:0]  p3_pull;
        logic        cap;
        logic [7:0]  p3_alt;
        logic        rdy;
        logic [31:0] rdata;
        logic        err;
    } state_t;

    state_t     q;
    state_t     d;
    logic       acc_first;
    logic       acc_done;
    logic       hit;
    logic [7:0] rd8;
    logic [7:0] p3_sel;
    logic [7:0] p1_oe_n;
    logic [7:0] p1_out_n;
    logic [7:0] p1_pull_exp;
    logic [7:0] p3_pull_exp;
    logic [7:0] p3_rd_exp;
    logic [7:0] wdata8;

    // All outputs come straight from the state register.
    assign pready                = q.rdy;
    assign prdata                = q.rdata;
    assign pslverr               = q.err;
    assign p1_pin_out            = q.p1_out;
    assign p1_pin_oe             = q.p1_oe;
    assign p1_pullup_on          = q.p1_pull;
    assign p3_pin_out            = q.p3_out;
    assign p3_pin_oe             = q.p3_oe;
    assign p3_pullup_on          = q.p3_pull;
    assign timer_capture_input   = q.cap;
    assign p3_alt_input          = q.p3_alt;
    assign port3_function_select = q.p3_fsel;

    // Assertion helpers, so that $past is handed plain signals, never expressions.
    assign p1_pull_exp = q.p1_pu & ~q.p1_dir;
    assign p3_pull_exp = q.p3_pu & ~q.p3_dir;
    assign p3_rd_exp   = (q.p3_lat & q.p3_dir) | (q.p3_sync2 & ~q.p3_dir);
    assign wdata8      = pwdata[7:0];

    // Next-state logic: synchronisers, register bus, and pin drive.
    always_comb begin
        d         = q;
        acc_first = psel && penable && !q.rdy;
        acc_done  = psel && penable && q.rdy;
        p3_sel    = q.p3_fsel & io_port_pkg::P3_PIN_SEL_MASK;
        // Pins are asynchronous; the first stage feeds only the second.
        d.p1_sync1 = p1_pin_in;
        d.p1_sync2 = q.p1_sync1;
        d.p3_sync1 = p3_pin_in;
        d.p3_sync2 = q.p3_sync1;

        // Read decode; data reads mix latch and live pin per direction bit.
        hit = 1'b1;
        unique case (paddr)
            io_port_pkg::P3_FSEL_ADDR: rd8 = q.p3_fsel;
            io_port_pkg::P3_LAT_ADDR:  rd8 = (q.p3_lat & q.p3_dir) | (q.p3_sync2 & ~q.p3_dir);
            io_port_pkg::P3_PU_ADDR:   rd8 = q.p3_pu;
            io_port_pkg::P3_DIR_ADDR:  rd8 = io_port_pkg::P3_DIR_READ;
            io_port_pkg::P1_FSEL_ADDR: rd8 = q.p1_fsel;
            io_port_pkg::P1_LAT_ADDR:  rd8 = (q.p1_lat & q.p1_dir) | (q.p1_sync2 & ~q.p1_dir);
            io_port_pkg::P1_PU_ADDR:   rd8 = q.p1_pu;
            io_port_pkg::P1_DIR_ADDR:  rd8 = q.p1_dir;
            default: begin
                rd8 = 8'h00;
                hit = 1'b0;
            end
        endcase

        // One wait state: data and error are captured in the first access cycle.
        d.rdy = acc_first;
        d.err = acc_first && !hit;
        if (acc_first) begin
            d.rdata = {24'h000000, rd8};
        end

        // Writes land on the edge at which pready is seen high.
        if (acc_done && pwrite) begin
            unique case (paddr)
                io_port_pkg::P3_FSEL_ADDR: d.p3_fsel = pwdata[7:0];
                io_port_pkg::P3_LAT_ADDR:  d.p3_lat  = pwdata[7:0];
                io_port_pkg::P3_PU_ADDR:   d.p3_pu   = pwdata[7:0];
                io_port_pkg::P3_DIR_ADDR:  d.p3_dir  = pwdata[7:0];
                io_port_pkg::P1_FSEL_ADDR: d.p1_fsel = pwdata[7:0];
                io_port_pkg::P1_LAT_ADDR:  d.p1_lat  = pwdata[7:0];
                io_port_pkg::P1_PU_ADDR:   d.p1_pu   = pwdata[7:0];
                io_port_pkg::P1_DIR_ADDR:  d.p1_dir  = pwdata[7:0];
                default: ;
            endcase
        end

        // Port 1 functional drive; timer functions override direction.
        p1_oe_n  = q.p1_dir;
        p1_out_n = q.p1_lat;
        if (q.p1_fsel[io_port_pkg::P1_CAPTURE_BIT]) begin
            p1_oe_n[io_port_pkg::P1_CAPTURE_BIT] = 1'b0;
        end
        if (q.p1_fsel[io_port_pkg::P1_TMR_HI_BIT]) begin
            p1_oe_n[io_port_pkg::P1_TMR_HI_BIT]  = 1'b1;
            p1_out_n[io_port_pkg::P1_TMR_HI_BIT] = timer_output_high;
        end
        if (q.p1_fsel[io_port_pkg::P1_TMR_LO_BIT]) begin
            p1_oe_n[io_port_pkg::P1_TMR_LO_BIT]  = 1'b1;
            p1_out_n[io_port_pkg::P1_TMR_LO_BIT] = timer_output_low;
        end
        if (q.p1_fsel[io_port_pkg::P1_WATCH_BIT]) begin
            p1_oe_n[io_port_pkg::P1_WATCH_BIT]  = 1'b1;
            p1_out_n[io_port_pkg::P1_WATCH_BIT] = watch_clock_output;
        end
        d.cap = q.p1_sync2[io_port_pkg::P1_CAPTURE_BIT] && q.p1_fsel[io_port_pkg::P1_CAPTURE_BIT];

        // Mode gating: sleeping modes keep the last drive untouched.
        unique case (op_mode)
            io_port_pkg::MODE_ACTIVE, io_port_pkg::MODE_SUBACTIVE: begin
                d.p1_oe   = p1_oe_n;
                d.p1_out  = p1_out_n;
                d.p1_pull = q.p1_pu & ~q.p1_dir;
            end
            io_port_pkg::MODE_SLEEP, io_port_pkg::MODE_SUBSLEEP, io_port_pkg::MODE_WATCH: begin
                d.p1_oe   = q.p1_oe;
                d.p1_out  = q.p1_out;
                d.p1_pull = q.p1_pull;
            end
            default: begin
                // Standby and any illegal code float the pins; pull-ups stay so
                // enabled inputs read high instead of floating.
                d.p1_oe   = 8'h00;
                d.p1_out  = 8'h00;
                d.p1_pull = q.p1_pu & ~q.p1_dir;
            end
        endcase

        // Port 3: latch and direction set the drive only on general pins; direction gates the pull-up on every pin.
        d.p3_oe  = (q.p3_dir & ~p3_sel) | (p3_sel & io_port_pkg::P3_ALT_OUT_MASK);
        d.p3_out = q.p3_lat & ~p3_sel;
        d.p3_out[io_port_pkg::P3_RESET_STAT_BIT] = p3_sel[io_port_pkg::P3_RESET_STAT_BIT]
            ? reset_status_output_n : q.p3_lat[io_port_pkg::P3_RESET_STAT_BIT];
        d.p3_out[io_port_pkg::P3_PWM_BIT] = p3_sel[io_port_pkg::P3_PWM_BIT]
            ? pwm_output : q.p3_lat[io_port_pkg::P3_PWM_BIT];
        d.p3_pull = q.p3_pu & ~q.p3_dir;
        d.p3_alt  = q.p3_sync2 & p3_sel & ~io_port_pkg::P3_ALT_OUT_MASK;
    end

    // State register; reset floats port 1 and leaves the reset status pin driving low.
    always_ff @(posedge ref_clk) begin
        if (!rst_n) begin
            q         <= '0;
            q.p1_lat  <= io_port_pkg::P1_LAT_RST;
            q.p1_dir  <= io_port_pkg::P1_DIR_RST;
            q.p1_pu   <= io_port_pkg::P1_PU_RST;
            q.p1_fsel <= io_port_pkg::P1_FSEL_RST;
            q.p3_lat  <= io_port_pkg::P3_LAT_RST;
            q.p3_dir  <= io_port_pkg::P3_DIR_RST;
            q.p3_pu   <= io_port_pkg::P3_PU_RST;
            q.p3_fsel <= io_port_pkg::P3_FSEL_RST;
            q.p3_oe   <= io_port_pkg::P3_OE_RST;
            q.p3_out  <= io_port_pkg::P3_OUT_RST;
        end else begin
            q <= d;
        end
    end

    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (!rst_n);

    property p_capture_select;
        (op_mode == io_port_pkg::MODE_ACTIVE) && q.p1_fsel[3] |=> !q.p1_oe[3];
    endproperty
    a_capture_select: assert property (p_capture_select)
        else $error("Capture pin driven while selected.");

    property p_timer_high;
        (op_mode == io_port_pkg::MODE_ACTIVE) && q.p1_fsel[2]
            |=> q.p1_oe[2] && (q.p1_out[2] == $past(timer_output_high));
    endproperty
    a_timer_high: assert property (p_timer_high)
        else $error("Timer high output not on its pin.");

    property p_watch_out;
        (op_mode == io_port_pkg::MODE_SUBACTIVE) && q.p1_fsel[0]
            |=> q.p1_oe[0] && (q.p1_out[0] == $past(watch_clock_output));
    endproperty
    a_watch_out: assert property (p_watch_out)
        else $error("Watch output not on its pin.");

    property p_sleep_hold;
        (op_mode == io_port_pkg::MODE_SLEEP) |=> $stable(q.p1_oe) && $stable(q.p1_out);
    endproperty
    a_sleep_hold: assert property (p_sleep_hold)
        else $error("Port 1 changed during sleep.");

    property p_standby_float;
        (op_mode == io_port_pkg::MODE_STANDBY)
            |=> (q.p1_oe == 8'h00) && (q.p1_pull == $past(p1_pull_exp));
    endproperty
    a_standby_float: assert property (p_standby_float)
        else $error("Port 1 standby state wrong.");

    property p_p1_pullup;
        (op_mode == io_port_pkg::MODE_ACTIVE) |=> q.p1_pull == $past(p1_pull_exp);
    endproperty
    a_p1_pullup: assert property (p_p1_pullup)
        else $error("Port 1 pull-up mismatch.");

    property p_reset_values;
        $rose(rst_n) |-> (q.p1_pull == 8'h00) && (q.p3_fsel == 8'h04) && (q.p3_pu == 8'h00)
            && (q.p3_dir == 8'h00) && (q.p3_lat == 8'h00) && q.p3_oe[2];
    endproperty
    a_reset_values: assert property (p_reset_values)
        else $error("Wrong value after reset.");

    property p_data_write;
        acc_done && pwrite && (paddr == io_port_pkg::P3_LAT_ADDR)
            |=> q.p3_lat == $past(wdata8);
    endproperty
    a_data_write: assert property (p_data_write)
        else $error("Port 3 latch write lost.");

    property p_data_read;
        acc_first && (paddr == io_port_pkg::P3_LAT_ADDR)
            |=> q.rdy && (q.rdata[7:0] == $past(p3_rd_exp));
    endproperty
    a_data_read: assert property (p_data_read)
        else $error("Port 3 data read wrong.");

    property p_dir_read;
        acc_first && (paddr == io_port_pkg::P3_DIR_ADDR) |=> q.rdata == 32'h000000ff;
    endproperty
    a_dir_read: assert property (p_dir_read)
        else $error("Direction read not all ones.");

    property p_general_pin;
        !q.p3_fsel[0] |=> (q.p3_oe[0] == $past(q.p3_dir[0]))
            && (q.p3_out[0] == $past(q.p3_lat[0]));
    endproperty
    a_general_pin: assert property (p_general_pin)
        else $error("General port 3 pin drive wrong.");

    property p_alt_pin;
        q.p3_fsel[7] |=> !q.p3_oe[7];
    endproperty
    a_alt_pin: assert property (p_alt_pin)
        else $error("Alternate input pin driven.");

    property p_p3_pullup;
        1'b1 |=> q.p3_pull == $past(p3_pull_exp);
    endproperty
    a_p3_pullup: assert property (p_p3_pullup)
        else $error("Port 3 pull-up mismatch.");

    property p_timer_low;
        (op_mode == io_port_pkg::MODE_ACTIVE) && q.p1_fsel[1]
            |=> q.p1_oe[1] && (q.p1_out[1] == $past(timer_output_low));
    endproperty
    a_timer_low: assert property (p_timer_low)
        else $error("Timer low output not on its pin.");

    // Only select bits 7, 6 and 1 are alternate inputs.
    property p_alt_input;
        1'b1 |=> q.p3_alt == ($past(q.p3_sync2) & $past(q.p3_fsel) & 8'hc2);
    endproperty
    a_alt_input: assert property (p_alt_input)
        else $error("Port 3 alternate input wrong.");

    property p_dir_write;
        acc_done && pwrite && (paddr == io_port_pkg::P3_DIR_ADDR)
            |=> q.p3_dir == $past(wdata8);
    endproperty
    a_dir_write: assert property (p_dir_write)
        else $error("Port 3 direction write lost.");

    property p_reset_status;
        q.p3_fsel[2] |=> q.p3_oe[2] && (q.p3_out[2] == $past(reset_status_output_n));
    endproperty
    a_reset_status: assert property (p_reset_status)
        else $error("Reset status output not on its pin.");

    cover property (acc_done && pwrite && (paddr == io_port_pkg::P3_DIR_ADDR));
    cover property (acc_first && !hit);
    cover property ((op_mode == io_port_pkg::MODE_STANDBY) && (q.p1_pull != 8'h00));
    cover property (q.p1_fsel[2] && (op_mode == io_port_pkg::MODE_ACTIVE));

endmodule : io_port_pin_control

// [testbench/io_pin_partner.sv]
`timescale 1ns/1ps
// Pads and outside world for both ports. A pin that nobody drives and whose
// pull-up is off floats; it toggles every cycle so a stale value never passes.
module io_pin_partner (
    input  wire logic       ref_clk,
    input  wire logic [7:0] p1_pin_out,
    input  wire logic [7:0] p1_pin_oe,
    input  wire logic [7:0] p1_pullup_on,
    input  wire logic [7:0] p3_pin_out,
    input  wire logic [7:0] p3_pin_oe,
    input  wire logic [7:0] p3_pullup_on,
    input  wire logic [7:0] ext1,
    input  wire logic [7:0] ext1_en,
    input  wire logic [7:0] ext3,
    input  wire logic [7:0] ext3_en,
    output logic      [7:0] p1_pin_in,
    output logic      [7:0] p3_pin_in
);
    logic [7:0] float_q = 8'h00;

    // Floating level changes each cycle.
    always @(posedge ref_clk) begin
        float_q <= ~float_q;
    end

    // Device drive wins, then the outside driver, then the pull-up, else float.
    function automatic logic [7:0] wire_lvl(input logic [7:0] oe, input logic [7:0] o,
                                            input logic [7:0] en, input logic [7:0] e,
                                            input logic [7:0] pu, input logic [7:0] fl);
        return (oe & o) | (~oe & en & e) | (~oe & ~en & pu) | (~oe & ~en & ~pu & fl);
    endfunction : wire_lvl

    // Resolved pad levels fed back to the block.
    assign p1_pin_in = wire_lvl(p1_pin_oe, p1_pin_out, ext1_en, ext1, p1_pullup_on, float_q);
    assign p3_pin_in = wire_lvl(p3_pin_oe, p3_pin_out, ext3_en, ext3, p3_pullup_on, float_q);
endmodule : io_pin_partner

// [testbench/test_io_port_pin_control.sv]
`timescale 1ns/1ps
module test_io_port_pin_control;
    logic                           ref_clk = 1'b0;
    logic                           rst_n, psel, penable, pwrite, pready, pslverr;
    logic [io_port_pkg::ADDR_W-1:0] paddr;
    logic [31:0]                    pwdata, prdata;
    io_port_pkg::op_mode_t          op_mode;
    logic [7:0]                     p1_pin_in, p1_pin_out, p1_pin_oe, p1_pullup_on;
    logic [7:0]                     p3_pin_in, p3_pin_out, p3_pin_oe, p3_pullup_on;
    logic [7:0]                     ext1, ext1_en, ext3, ext3_en, p3_alt_input, fsel3;
    logic                           tmr_hi, tmr_lo, watch_out, pwm_out, rst_stat_n, capture;
    logic [7:0]                     rd;
    logic                           err;
    int                             n_fail = 0;
    int                             cmp_count = 0;
    int                             cyc = 0;

    io_port_pin_control io_port_pin_control_inst (.ref_clk(ref_clk), .rst_n(rst_n),
        .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
        .pready(pready), .prdata(prdata), .pslverr(pslverr), .op_mode(op_mode),
        .p1_pin_in(p1_pin_in), .p1_pin_out(p1_pin_out), .p1_pin_oe(p1_pin_oe),
        .p1_pullup_on(p1_pullup_on), .p3_pin_in(p3_pin_in), .p3_pin_out(p3_pin_out),
        .p3_pin_oe(p3_pin_oe), .p3_pullup_on(p3_pullup_on), .timer_output_high(tmr_hi),
        .timer_output_low(tmr_lo), .watch_clock_output(watch_out), .pwm_output(pwm_out),
        .reset_status_output_n(rst_stat_n), .timer_capture_input(capture),
        .p3_alt_input(p3_alt_input), .port3_function_select(fsel3));

    io_pin_partner io_pin_partner_inst (.ref_clk(ref_clk), .p1_pin_out(p1_pin_out),
        .p1_pin_oe(p1_pin_oe), .p1_pullup_on(p1_pullup_on), .p3_pin_out(p3_pin_out),
        .p3_pin_oe(p3_pin_oe), .p3_pullup_on(p3_pullup_on), .ext1(ext1), .ext1_en(ext1_en),
        .ext3(ext3), .ext3_en(ext3_en), .p1_pin_in(p1_pin_in), .p3_pin_in(p3_pin_in));

    // 50 MHz clock.
    always #10 ref_clk = ~ref_clk;

    task automatic end_sim;
        $display("comparisons %0d mismatches %0d", cmp_count, n_fail);
        if (n_fail == 0 && cmp_count > 0) begin
            $display("STATUS OK");
        end else begin
            $display("STATUS NOT OK");
        end
        $finish;
    endtask : end_sim

    // A hang ends the run; the tests need well under a thousand cycles.
    always @(posedge ref_clk) begin
        cyc <= cyc + 1;
        if (cyc == 5000) begin
            n_fail++;
            end_sim();
        end
    end

    task automatic check(input string what, input logic [31:0] exp, input logic [31:0] got);
        cmp_count++;
        if (got !== exp) begin
            n_fail++;
            $display("Error %s expected %h seen %h", what, exp, got);
        end
    endtask : check

    // One APB transfer; data and error are taken at the edge that sees pready high.
    task automatic apb(input logic wr, input logic [io_port_pkg::ADDR_W-1:0] a,
                       input logic [7:0] d);
        psel    <= 1'b1;
        penable <= 1'b0;
        pwrite  <= wr;
        paddr   <= a;
        pwdata  <= {24'h000000, d};
        @(posedge ref_clk);
        penable <= 1'b1;
        // No wait count is assumed; only the bench timeout ends a hang.
        do begin
            @(posedge ref_clk);
        end while (pready !== 1'b1);
        rd  = prdata[7:0];
        err = pslverr;
        psel    <= 1'b0;
        penable <= 1'b0;
        repeat (4) @(posedge ref_clk);
    endtask : apb

    task automatic rd_chk(input string what, input logic [io_port_pkg::ADDR_W-1:0] a,
                          input logic [7:0] exp);
        apb(1'b0, a, 8'h00);
        check(what, {24'h000000, exp}, {24'h000000, rd});
    endtask : rd_chk

    initial begin
        {rst_n, psel, penable, pwrite, tmr_hi, tmr_lo, watch_out, pwm_out} = 8'h00;
        paddr = '0;
        pwdata = 32'h00000000;
        op_mode = io_port_pkg::MODE_ACTIVE;
        rst_stat_n = 1'b1;
        {ext1, ext1_en, ext3, ext3_en} = 32'h00000000;
        repeat (19) @(posedge ref_clk);
        check("p1 oe in reset", 32'h00, {24'h0, p1_pin_oe});
        @(posedge ref_clk);
        rst_n <= 1'b1;
        @(posedge ref_clk);
        check("p3 oe", 32'h04, {24'h0, p3_pin_oe});
        check("p1 pull", 32'h00, {24'h0, p1_pullup_on});
        check("fsel port", 32'h04, {24'h0, fsel3});
        rd_chk("fsel3", io_port_pkg::P3_FSEL_ADDR, 8'h04);
        rd_chk("pu3", io_port_pkg::P3_PU_ADDR, 8'h00);
        rd_chk("dir3", io_port_pkg::P3_DIR_ADDR, 8'hff);
        $display("test reset done");
        // Port 3 general outputs drive the latch.
        apb(1'b1, io_port_pkg::P3_FSEL_ADDR, 8'h00);
        apb(1'b1, io_port_pkg::P3_DIR_ADDR, 8'hff);
        apb(1'b1, io_port_pkg::P3_LAT_ADDR, 8'ha5);
        check("p3 oe", 32'hff, {24'h0, p3_pin_oe});
        check("p3 out", 32'ha5, {24'h0, p3_pin_out});
        rd_chk("lat3", io_port_pkg::P3_LAT_ADDR, 8'ha5);
        rd_chk("dir3", io_port_pkg::P3_DIR_ADDR, 8'hff);
        // Mixed directions: inputs read the pads, outputs the latch.
        ext3 <= 8'h3c;
        ext3_en <= 8'hff;
        apb(1'b1, io_port_pkg::P3_DIR_ADDR, 8'h0f);
        rd_chk("lat3 mix", io_port_pkg::P3_LAT_ADDR, 8'h35);
        apb(1'b1, io_port_pkg::P3_PU_ADDR, 8'hff);
        check("p3 pull", 32'hf0, {24'h0, p3_pullup_on});
        rd_chk("pu3", io_port_pkg::P3_PU_ADDR, 8'hff);
        $display("test port3 general done");
        // Alternate outputs override the latch on bits 0 and 2.
        apb(1'b1, io_port_pkg::P3_DIR_ADDR, 8'hff);
        pwm_out <= 1'b0;
        rst_stat_n <= 1'b0;
        apb(1'b1, io_port_pkg::P3_FSEL_ADDR, 8'h05);
        check("p3 alt out", 32'ha0, {24'h0, p3_pin_out});
        apb(1'b1, io_port_pkg::P3_FSEL_ADDR, 8'h00);
        check("p3 general", 32'ha5, {24'h0, p3_pin_out});
        // Unmapped place: error, zero data, nothing stored.
        apb(1'b1, 18'h00000, 8'h11);
        check("unmapped err", 32'h1, {31'h0, err});
        rd_chk("unmapped rd", 18'h00000, 8'h00);
        rd_chk("lat3 kept", io_port_pkg::P3_LAT_ADDR, 8'ha5);
        // Alternate inputs on bits 7, 6, 1: pins released, levels passed on.
        ext3 <= 8'h83;
        apb(1'b1, io_port_pkg::P3_FSEL_ADDR, 8'hc2);
        repeat (2) @(posedge ref_clk);
        check("p3 alt oe", 32'h3d, {24'h0, p3_pin_oe});
        check("p3 alt in", 32'h82, {24'h0, p3_alt_input});
        check("pready idle", 32'h0, {31'h0, pready});
        $display("test port3 alternate done");
        // Port 1 timer pins take over from the latch when selected.
        apb(1'b1, io_port_pkg::P1_DIR_ADDR, 8'hff);
        apb(1'b1, io_port_pkg::P1_LAT_ADDR, 8'h5a);
        check("p1 out", 32'h5a, {24'h0, p1_pin_out});
        tmr_hi <= 1'b1;
        watch_out <= 1'b1;
        apb(1'b1, io_port_pkg::P1_FSEL_ADDR, 8'h06);
        check("p1 timers", 32'h5c, {24'h0, p1_pin_out});
        op_mode <= io_port_pkg::MODE_SUBACTIVE;
        apb(1'b1, io_port_pkg::P1_FSEL_ADDR, 8'h01);
        check("p1 watch", 32'h5b, {24'h0, p1_pin_out});
        op_mode <= io_port_pkg::MODE_ACTIVE;
        ext1 <= 8'h08;
        ext1_en <= 8'h08;
        apb(1'b1, io_port_pkg::P1_DIR_ADDR, 8'h07);
        apb(1'b1, io_port_pkg::P1_FSEL_ADDR, 8'h08);
        check("capture on", 32'h1, {31'h0, capture});
        apb(1'b1, io_port_pkg::P1_FSEL_ADDR, 8'h00);
        check("capture off", 32'h0, {31'h0, capture});
        $display("test port1 timers done");
        // Pull-ups and operating modes.
        ext1_en <= 8'h00;
        apb(1'b1, io_port_pkg::P1_DIR_ADDR, 8'h0f);
        apb(1'b1, io_port_pkg::P1_PU_ADDR, 8'hff);
        check("p1 pull", 32'hf0, {24'h0, p1_pullup_on});
        op_mode <= io_port_pkg::MODE_SLEEP;
        apb(1'b1, io_port_pkg::P1_LAT_ADDR, 8'h00);
        check("sleep hold", 32'h0f5a, {16'h0, p1_pin_oe, p1_pin_out});
        op_mode <= io_port_pkg::MODE_ACTIVE;
        repeat (3) @(posedge ref_clk);
        check("active out", 32'h00, {24'h0, p1_pin_out});
        op_mode <= io_port_pkg::MODE_STANDBY;
        repeat (3) @(posedge ref_clk);
        check("standby oe", 32'h00, {24'h0, p1_pin_oe});
        check("standby pull", 32'hf0, {24'h0, p1_pullup_on});
        $display("test port1 modes done");
        // A second reset in mid-run restores the defaults.
        op_mode <= io_port_pkg::MODE_ACTIVE;
        rst_n <= 1'b0;
        repeat (2) @(posedge ref_clk);
        rst_n <= 1'b1;
        @(posedge ref_clk);
        check("p1 pull rerst", 32'h00, {24'h0, p1_pullup_on});
        rd_chk("fsel3 rerst", io_port_pkg::P3_FSEL_ADDR, 8'h04);
        $display("test mid reset done");
        end_sim();
    end
endmodule : test_io_port_pin_control
